// file: rtl/svof_framer.v
// Purpose: output framer of an image sensor: window readout, 2x2 averaging,
//          output crop/pad, frame markers and blanking for two link kinds
// Assumes: the pixel array answers pix_x_o/pix_y_o combinationally on
//          pixel_i; pixel enables are at least 6 clocks apart
// Notes:   serialisation and line drivers sit outside this block
`timescale 1ns/1ps
`include "svof_defs.vh"
`default_nettype none

module svof_framer #(
    parameter PIX_W = 10
) (
    input  wire             ref_clk_i,
    input  wire             rstn_i,
    input  wire [15:0]      reg_addr_i,
    input  wire [7:0]       reg_wdata_i,
    input  wire             reg_we_i,
    output reg  [7:0]       reg_rdata_o,
    input  wire             stream_i,
    output reg              streaming_o,
    output reg  [10:0]      pix_x_o,
    output reg  [10:0]      pix_y_o,
    input  wire [PIX_W-1:0] pixel_i,
    output reg  [PIX_W-1:0] vid_data_o,
    output reg  [2:0]       vid_kind_o,
    output reg              vid_lp_o,
    output reg  [1:0]       vid_link_o
);

// ----------------------------------------------------------------
// address decode: {valid, hi byte, word index}
// ----------------------------------------------------------------
function [5:0] dec;
    input [15:0] a;
    begin
        if (a == `SVOF_A_LINK_SEL) dec = 6'h20;
        else if (a == `SVOF_A_AVG_SEL) dec = 6'h21;
        else if (a[15:1] == `SVOF_A_LINE_LEN >> 1) dec = {2'b10, a[0] ? 4'h2 : 4'h2} | {1'b0, ~a[0], 4'h0};
        else if (a[15:1] == `SVOF_A_FRAME_LEN >> 1) dec = {1'b1, ~a[0], 4'h3};
        else if (a[15:1] == `SVOF_A_X_START >> 1) dec = {1'b1, ~a[0], 4'h4};
        else if (a[15:1] == `SVOF_A_Y_START >> 1) dec = {1'b1, ~a[0], 4'h5};
        else if (a[15:1] == `SVOF_A_X_END >> 1) dec = {1'b1, ~a[0], 4'h6};
        else if (a[15:1] == `SVOF_A_Y_END >> 1) dec = {1'b1, ~a[0], 4'h7};
        else if (a[15:1] == `SVOF_A_X_OUT >> 1) dec = {1'b1, ~a[0], 4'h8};
        else if (a[15:1] == `SVOF_A_Y_OUT >> 1) dec = {1'b1, ~a[0], 4'h9};
        else if (a[15:1] == `SVOF_A_PRE_DIV >> 1) dec = {1'b1, ~a[0], 4'hA};
        else if (a[15:1] == `SVOF_A_PLL_MULT >> 1) dec = {1'b1, ~a[0], 4'hB};
        else if (a[15:1] == `SVOF_A_SYS_DIV >> 1) dec = {1'b1, ~a[0], 4'hC};
        else if (a[15:1] == `SVOF_A_PIX_DIV >> 1) dec = {1'b1, ~a[0], 4'hD};
        else if (a[15:1] == `SVOF_A_INT_TIME >> 1) dec = {1'b1, ~a[0], 4'hE};
        else if (a[15:1] == `SVOF_A_GAIN >> 1) dec = {1'b1, ~a[0], 4'hF};
        else dec = 6'h00;
    end
endfunction

// reset value of each word
function [15:0] rst_val;
    input [3:0] i;
    begin
        case (i)
            4'h0:    rst_val = {14'h0000, `SVOF_LINK_CSI};
            4'h2:    rst_val = `SVOF_RST_LINE;
            4'h3:    rst_val = `SVOF_RST_FRAME;
            4'h6:    rst_val = `SVOF_X_MAX;
            4'h7:    rst_val = `SVOF_Y_MAX;
            4'h8:    rst_val = `SVOF_RST_X_OUT;
            4'h9:    rst_val = `SVOF_RST_Y_OUT;
            4'hA:    rst_val = 16'h0001;
            4'hB:    rst_val = `SVOF_RST_MULT;
            4'hC:    rst_val = 16'h0001;
            4'hD:    rst_val = `SVOF_RST_PIX_DIV;
            4'hE:    rst_val = `SVOF_RST_INT;
            default: rst_val = 16'h0000;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// shadow registers written by the host, active copies used by logic
// ----------------------------------------------------------------
reg  [15:0] shd_q [0:15];
reg  [15:0] act_q [0:15];
reg  [7:0]  frame_cnt_q;
wire [5:0]  wdec = dec(reg_addr_i);
wire [5:0]  rdec = dec(reg_addr_i);
wire [15:0] rword = shd_q[rdec[3:0]];
integer     i;

// byte writes into the shadow words
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        for (i = 0; i < 16; i = i + 1) begin
            shd_q[i] <= rst_val(i[3:0]);
        end
    end else if (reg_we_i && wdec[5]) begin
        if (wdec[4]) begin
            shd_q[wdec[3:0]][15:8] <= reg_wdata_i;
        end else begin
            shd_q[wdec[3:0]][7:0] <= reg_wdata_i;
        end
    end
end

// read data: shadow words, frame counter, zero elsewhere
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        reg_rdata_o <= 8'h00;
    end else if (reg_addr_i == `SVOF_A_STATUS) begin
        reg_rdata_o <= frame_cnt_q;
    end else if (rdec[5]) begin
        reg_rdata_o <= rdec[4] ? rword[15:8] : rword[7:0];
    end else begin
        reg_rdata_o <= 8'h00;
    end
end

// ----------------------------------------------------------------
// pixel clock enable: fractional divider on the external clock
// ----------------------------------------------------------------
reg  [23:0] pacc_q;
reg         pix_en_q;
wire [23:0] pdiv = act_q[10][7:0] * act_q[12][7:0] * act_q[13][7:0];
wire [23:0] pdiv1 = (pdiv == 24'h000000) ? 24'h000001 : pdiv;
wire [23:0] pacc_d = pacc_q + {8'h00, act_q[11]};

// one enable per period of the pixel clock, at most one per cycle
always @(posedge ref_clk_i) begin
    if (!rstn_i || !streaming_o) begin
        pacc_q   <= 24'h000000;
        pix_en_q <= 1'b0;
    end else if (pacc_d >= pdiv1) begin
        pacc_q   <= (pacc_d - pdiv1 >= pdiv1) ? 24'h000000 : pacc_d - pdiv1;
        pix_en_q <= 1'b1;
    end else begin
        pacc_q   <= pacc_d;
        pix_en_q <= 1'b0;
    end
end

// ----------------------------------------------------------------
// frame timing counters
// ----------------------------------------------------------------
reg  [15:0] col_q;
reg  [15:0] row_q;
reg         stream_q;
wire        bin = act_q[1][0];
wire [15:0] line_len = (bin && act_q[2] < `SVOF_BIN_MIN_LINE) ?
                       `SVOF_BIN_MIN_LINE : act_q[2];
wire        line_end = (col_q >= line_len - 16'h0001);
wire        frm_end = line_end && (row_q >= act_q[3] - 16'h0001);
wire        frm_start = pix_en_q && frm_end;
wire        go = stream_i && !stream_q;
integer     k;

// streaming state; pll and link set taken at the stream start only
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        stream_q    <= 1'b0;
        streaming_o <= 1'b0;
        frame_cnt_q <= 8'h00;
        for (k = 0; k < 16; k = k + 1) begin
            act_q[k] <= rst_val(k[3:0]);
        end
    end else begin
        stream_q    <= stream_i;
        streaming_o <= stream_i;
        if (go) begin
            for (k = 0; k < 16; k = k + 1) begin
                act_q[k] <= shd_q[k];
            end
        end else if (frm_start) begin
            frame_cnt_q <= frame_cnt_q + 8'h01;
            for (k = 1; k < 10; k = k + 1) begin
                act_q[k] <= shd_q[k];
            end
            act_q[14] <= shd_q[14];
            act_q[15] <= shd_q[15];
        end
    end
end

// column and row counters in pixel clocks and lines
always @(posedge ref_clk_i) begin
    if (!rstn_i || go || !stream_i) begin
        col_q <= 16'h0000;
        row_q <= 16'h0000;
    end else if (pix_en_q) begin
        col_q <= line_end ? 16'h0000 : col_q + 16'h0001;
        if (frm_end) begin
            row_q <= 16'h0000;
        end else if (line_end) begin
            row_q <= row_q + 16'h0001;
        end
    end
end

// ----------------------------------------------------------------
// array fetch: one sample, or four in 2x2 averaging
// ----------------------------------------------------------------
reg  [2:0]  fcnt_q;
reg  [11:0] facc_q;
reg  [11:0] fres_q;
reg         fpad_q;
reg         fpad_res_q;
wire [15:0] ox = col_q - 16'h0001;
wire [15:0] oy = row_q - `SVOF_EMB_LINES;
wire [15:0] step = bin ? 16'h0002 : 16'h0001;
wire [2:0]  nsamp = bin ? 3'h4 : 3'h1;
wire [1:0]  ph = fcnt_q[1:0] - 2'h1;
wire [15:0] ax = act_q[4] + ox * step + {15'h0000, bin & ph[0]};
wire [15:0] ay = act_q[5] + oy * step + {15'h0000, bin & ph[1]};
wire        opad = (ax > act_q[6]) || (ay > act_q[7]);
// clamp to the addressable array before cutting to the port width
wire [15:0] ax_c = (ax > `SVOF_X_MAX) ? `SVOF_X_MAX : ax;
wire [15:0] ay_c = (ay > `SVOF_Y_MAX) ? `SVOF_Y_MAX : ay;

// fetch window pixels, clamped to the addressable array
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        fcnt_q     <= 3'h0;
        facc_q     <= 12'h000;
        fres_q     <= 12'h000;
        fpad_q     <= 1'b0;
        fpad_res_q <= 1'b0;
        pix_x_o    <= 11'h000;
        pix_y_o    <= 11'h000;
    end else if (pix_en_q) begin
        fcnt_q     <= 3'h1;
        facc_q     <= 12'h000;
        fres_q     <= facc_q;
        fpad_res_q <= fpad_q;
        fpad_q     <= 1'b0;
    end else if (fcnt_q != 3'h0) begin
        if (fcnt_q <= nsamp) begin
            pix_x_o <= ax_c[10:0];
            pix_y_o <= ay_c[10:0];
            fpad_q  <= fpad_q | opad;
        end
        if (fcnt_q >= 3'h2) begin
            facc_q <= facc_q + (bin ? {2'b00, pixel_i} : {pixel_i, 2'b00});
        end
        fcnt_q <= (fcnt_q > nsamp) ? 3'h0 : fcnt_q + 3'h1;
    end
end

// ----------------------------------------------------------------
// output stream: markers, embedded lines, pixels, blanking
// ----------------------------------------------------------------
wire [15:0] yo = act_q[9];
wire [15:0] xo = act_q[8];
wire [15:0] vis_rows = `SVOF_EMB_LINES + yo;
wire        in_frame = row_q < vis_rows;
wire        last_row = (row_q == vis_rows - 16'h0001);
wire [15:0] dcol = col_q - 16'h0002;
wire        ccp = act_q[0][1:0] != `SVOF_LINK_CSI;
reg  [PIX_W-1:0] emb;

// embedded content: integration time then gain of this frame
always @* begin
    case (dcol)
        16'h0000: emb = {{(PIX_W-8){1'b0}}, act_q[14][15:8]};
        16'h0001: emb = {{(PIX_W-8){1'b0}}, act_q[14][7:0]};
        16'h0002: emb = {{(PIX_W-8){1'b0}}, act_q[15][15:8]};
        16'h0003: emb = {{(PIX_W-8){1'b0}}, act_q[15][7:0]};
        default:  emb = {PIX_W{1'b0}};
    endcase
end

// per pixel clock: one symbol of the selected link
always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
        vid_data_o <= {PIX_W{1'b0}};
        vid_kind_o <= `SVOF_K_BLANK;
        vid_lp_o   <= 1'b1;
        vid_link_o <= `SVOF_LINK_CSI;
    end else if (!streaming_o) begin
        vid_kind_o <= `SVOF_K_BLANK;
        vid_lp_o   <= 1'b1;
        vid_data_o <= {PIX_W{1'b1}};
        vid_link_o <= act_q[0][1:0];
    end else if (pix_en_q) begin
        vid_link_o <= act_q[0][1:0];
        if (in_frame && col_q == 16'h0000) begin
            vid_kind_o <= (row_q == 16'h0000) ? `SVOF_K_FS : `SVOF_K_LS;
            vid_lp_o   <= 1'b0;
            vid_data_o <= {PIX_W{1'b0}};
        end else if (in_frame && col_q >= 16'h0002 &&
                     dcol < xo) begin
            vid_lp_o <= 1'b0;
            if (row_q < `SVOF_EMB_LINES) begin
                vid_kind_o <= `SVOF_K_EMB;
                vid_data_o <= emb;
            end else begin
                vid_kind_o <= `SVOF_K_PIX;
                vid_data_o <= fpad_res_q ? {PIX_W{1'b0}} :
                              fres_q[PIX_W+1:2];
            end
        end else if (in_frame && dcol == xo) begin
            vid_kind_o <= last_row ? `SVOF_K_FE : `SVOF_K_LE;
            vid_lp_o   <= 1'b0;
            vid_data_o <= {PIX_W{1'b0}};
        end else begin
            vid_kind_o <= `SVOF_K_BLANK;
            vid_lp_o   <= ~ccp;
            vid_data_o <= {PIX_W{1'b1}};
        end
    end else if (vid_kind_o == `SVOF_K_BLANK) begin
        // stream start: show the new link before the first pixel enable
        vid_link_o <= act_q[0][1:0];
        vid_lp_o   <= ~ccp;
    end
end

endmodule
`default_nettype wire

// file: shared/svof_defs.vh
// Purpose: constants of the sensor video output framer
// Assumes: byte-wide register port, 16-bit words as hi/lo byte pairs
// Notes:   clock is 100 MHz; the pixel rate comes from an enable divider
`ifndef SVOF_DEFS_VH
`define SVOF_DEFS_VH

// ----------------------------------------------------------------
// register byte addresses (16-bit words: hi byte at the even address)
// ----------------------------------------------------------------
`define SVOF_A_LINK_SEL   16'h0111
`define SVOF_A_AVG_SEL    16'h0900
`define SVOF_A_STATUS     16'h0005
`define SVOF_A_FRAME_LEN  16'h0340
`define SVOF_A_LINE_LEN   16'h0342
`define SVOF_A_X_START    16'h0344
`define SVOF_A_Y_START    16'h0346
`define SVOF_A_X_END      16'h0348
`define SVOF_A_Y_END      16'h034A
`define SVOF_A_X_OUT      16'h034C
`define SVOF_A_Y_OUT      16'h034E
`define SVOF_A_PIX_DIV    16'h0300
`define SVOF_A_SYS_DIV    16'h0302
`define SVOF_A_PRE_DIV    16'h0304
`define SVOF_A_PLL_MULT   16'h0306
`define SVOF_A_INT_TIME   16'h0202
`define SVOF_A_GAIN       16'h0204

// ----------------------------------------------------------------
// link select values and output kinds
// ----------------------------------------------------------------
`define SVOF_LINK_CCP_DC  2'h0
`define SVOF_LINK_CCP_DS  2'h1
`define SVOF_LINK_CSI     2'h2
`define SVOF_K_BLANK      3'h0
`define SVOF_K_FS         3'h1
`define SVOF_K_LS         3'h2
`define SVOF_K_EMB        3'h3
`define SVOF_K_PIX        3'h4
`define SVOF_K_LE         3'h5
`define SVOF_K_FE         3'h6

// ----------------------------------------------------------------
// reset values, limits, rates
// ----------------------------------------------------------------
`define SVOF_EMB_LINES    16'h0002
`define SVOF_BIN_MIN_LINE 16'h0A50
`define SVOF_X_MAX        16'h050F
`define SVOF_Y_MAX        16'h03CF
`define SVOF_RST_LINE     16'h0A50
`define SVOF_RST_FRAME    16'h03EE
`define SVOF_RST_X_OUT    16'h0510
`define SVOF_RST_Y_OUT    16'h03D0
`define SVOF_RST_MULT     16'h0053
`define SVOF_RST_PIX_DIV  16'h000A
`define SVOF_RST_INT      16'h0010
`define SVOF_CSI_MBPS     800
`define SVOF_CCP_MBPS     640
`define SVOF_CLK_MHZ      100
`endif

// file: test/svof_framer_asserts.sv
// Purpose: port checker of the video output framer
// Assumes: constants of svof_defs.vh
// Notes:   bound to every framer instance
`timescale 1ns/1ps
`include "svof_defs.vh"
`default_nettype none
module svof_framer_asserts #(
    parameter PIX_W = 10
) (
    input wire             ref_clk_i,
    input wire             rstn_i,
    input wire [15:0]      reg_addr_i,
    input wire [7:0]       reg_wdata_i,
    input wire             reg_we_i,
    input wire [7:0]       reg_rdata_o,
    input wire             stream_i,
    input wire             streaming_o,
    input wire [10:0]      pix_x_o,
    input wire [10:0]      pix_y_o,
    input wire [PIX_W-1:0] pixel_i,
    input wire [PIX_W-1:0] vid_data_o,
    input wire [2:0]       vid_kind_o,
    input wire             vid_lp_o,
    input wire [1:0]       vid_link_o
);
    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    reset_state_a: assert property ($rose(rstn_i) |->
        vid_link_o == `SVOF_LINK_CSI && vid_lp_o && !streaming_o)
        else $error("reset state wrong");
    csi_blank_lp_a: assert property (streaming_o && $past(streaming_o, 8)
        && vid_link_o == `SVOF_LINK_CSI && vid_kind_o == `SVOF_K_BLANK
        |-> vid_lp_o) else $error("csi blank not in low power");
    ccp_blank_ones_a: assert property (streaming_o && $past(streaming_o, 8)
        && vid_link_o != `SVOF_LINK_CSI && vid_kind_o == `SVOF_K_BLANK
        |-> (&vid_data_o) && !vid_lp_o) else $error("ccp blank not ones");
    link_hold_a: assert property (streaming_o && $past(streaming_o, 8)
        |-> $stable(vid_link_o)) else $error("link changed while streaming");
    start_order_a: assert property (vid_kind_o inside {`SVOF_K_FS,
        `SVOF_K_LS} |=> vid_kind_o == $past(vid_kind_o)
        || vid_kind_o == `SVOF_K_BLANK) else $error("bad marker order");
    pixel_end_a: assert property (vid_kind_o == `SVOF_K_PIX |=>
        vid_kind_o inside {`SVOF_K_PIX, `SVOF_K_LE, `SVOF_K_FE, `SVOF_K_BLANK})
        else $error("pixels not closed by end code");
    avg_readback_a: assert property (
        reg_we_i && reg_addr_i == `SVOF_A_AVG_SEL
        ##1 reg_addr_i == `SVOF_A_AVG_SEL && !reg_we_i
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("avg readback");
    array_range_a: assert property (
        pix_x_o <= 11'h50F && pix_y_o <= 11'h3CF)
        else $error("array address out of range");
endmodule
bind svof_framer svof_framer_asserts #(.PIX_W(PIX_W)) svof_framer_asserts_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o),
    .stream_i(stream_i), .streaming_o(streaming_o), .pix_x_o(pix_x_o),
    .pix_y_o(pix_y_o), .pixel_i(pixel_i), .vid_data_o(vid_data_o),
    .vid_kind_o(vid_kind_o), .vid_lp_o(vid_lp_o), .vid_link_o(vid_link_o));
`default_nettype wire

// file: test/svof_pixel_array.sv
// Purpose: pixel array model answering the framer's address
// Assumes: answer is combinational, same cycle
// Notes:   pattern tells row and column apart
`timescale 1ns/1ps
`default_nettype none
module svof_pixel_array (
    input  wire logic [10:0] x_i,
    input  wire logic [10:0] y_i,
    output var logic  [9:0]  pixel_o
);
    // ------------------------------------------------
    // sample pattern
    // ------------------------------------------------
    // outside the array the answer is inverted so stale use shows
    always_comb begin
        if (x_i > 11'h50F || y_i > 11'h3CF) pixel_o = ~{y_i[4:0], x_i[4:0]};
        else pixel_o = {y_i[4:0], x_i[4:0]};
    end
endmodule
`default_nettype wire

// file: test/svof_framer_tb.sv
// Purpose: self-checking bench of the video output framer
// Assumes: pixel enable every (pre*sys*pix)/mult clocks
// Notes:   small frames keep the run short
`timescale 1ns/1ps
`include "svof_defs.vh"
`default_nettype none
module svof_framer_tb;
    logic        ref_clk_i, rstn_i, reg_we_i, stream_i;
    logic [15:0] reg_addr_i;
    logic [7:0]  reg_wdata_i;
    wire  [7:0]  reg_rdata_o;
    wire         streaming_o, vid_lp_o;
    wire  [10:0] pix_x_o, pix_y_o;
    wire  [9:0]  pixel_i, vid_data_o;
    wire  [2:0]  vid_kind_o;
    wire  [1:0]  vid_link_o;
    int          failures, check_count, cyc;
    int          cnt [0:7];
    int          fs_t [0:7];
    logic [2:0]  prev_kind;
    logic [9:0]  prev_data;
    logic [9:0]  last_pix;
    logic [7:0]  emb_q [$];
    svof_framer svof_framer_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o), .stream_i(stream_i),
        .streaming_o(streaming_o), .pix_x_o(pix_x_o), .pix_y_o(pix_y_o),
        .pixel_i(pixel_i), .vid_data_o(vid_data_o), .vid_kind_o(vid_kind_o),
        .vid_lp_o(vid_lp_o), .vid_link_o(vid_link_o));
    svof_pixel_array svof_pixel_array_inst (.x_i(pix_x_o), .y_i(pix_y_o),
        .pixel_o(pixel_i));
    // ------------------------------------------------
    // clock, monitor, timeout
    // ------------------------------------------------
    initial begin
        ref_clk_i = 0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // counts entries of each output kind and stamps each frame start
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            failures++;
            give_verdict();
        end
        if (vid_kind_o !== prev_kind) cnt[vid_kind_o]++;
        if (vid_kind_o !== prev_kind && vid_kind_o === `SVOF_K_FS)
            fs_t[cnt[1] & 7] = cyc;
        if (vid_kind_o === `SVOF_K_EMB && (prev_kind !== `SVOF_K_EMB
            || vid_data_o !== prev_data)) emb_q.push_back(vid_data_o[7:0]);
        if (vid_kind_o === `SVOF_K_PIX) last_pix = vid_data_o;
        prev_kind = vid_kind_o;
        prev_data = vid_data_o;
    end
    task automatic check_eq(input string what, input logic [15:0] e,
                            input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    // n bytes: one, or a hi/lo pair starting at the even address
    task automatic wr(input logic [15:0] a, input logic [15:0] v, input int n);
        @(posedge ref_clk_i);
        #1 reg_we_i = 1;
        reg_addr_i = a;
        reg_wdata_i = (n == 2) ? v[15:8] : v[7:0];
        if (n == 2) begin
            @(posedge ref_clk_i);
            #1 reg_addr_i = a + 16'h0001;
            reg_wdata_i = v[7:0];
        end
        @(posedge ref_clk_i);
        #1 reg_we_i = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge ref_clk_i);
        #1 reg_addr_i = a;
        @(posedge ref_clk_i);
        #1 v = reg_rdata_o;
    endtask
    task automatic wait_fs(input int n);
        for (int k = 0; k < 4000 && cnt[1] < n; k++) begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask
    task automatic restart();
        repeat (40) @(posedge ref_clk_i);
        #1 emb_q.delete();
        for (int k = 0; k < 8; k++) cnt[k] = 0;
        stream_i = 1;
    endtask
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic scen_reset();
        logic [7:0] v;
        check_eq("link out", 16'h0002, {14'h0000, vid_link_o});
        check_eq("lp out", 16'h0001, {15'h0000, vid_lp_o});
        rd(`SVOF_A_LINK_SEL, v);
        check_eq("link reg", 16'h0002, {8'h00, v});
        wr(`SVOF_A_AVG_SEL, 16'h0001, 1);
        rd(`SVOF_A_AVG_SEL, v);
        check_eq("avg reg", 16'h0001, {8'h00, v});
        wr(`SVOF_A_AVG_SEL, 16'h0000, 1);
        rd(`SVOF_A_AVG_SEL, v);
        check_eq("avg reg", 16'h0000, {8'h00, v});
    endtask
    // one 6x10 frame, then a longer 7x10 one from a mid-frame write
    task automatic scen_csi();
        logic [7:0] e [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
        wr(`SVOF_A_FRAME_LEN, 16'h0006, 2);
        wr(`SVOF_A_LINE_LEN, 16'h000A, 2);
        wr(`SVOF_A_X_OUT, 16'h0004, 2);
        wr(`SVOF_A_Y_OUT, 16'h0002, 2);
        wr(`SVOF_A_PLL_MULT, 16'h0001, 2);
        wr(`SVOF_A_PIX_DIV, 16'h0008, 2);
        wr(`SVOF_A_INT_TIME, 16'h1234, 2);
        wr(`SVOF_A_GAIN, 16'h5678, 2);
        restart();
        wait_fs(1);
        wr(`SVOF_A_FRAME_LEN, 16'h0007, 2);
        wr(`SVOF_A_PRE_DIV, 16'h0002, 2);
        wr(`SVOF_A_LINK_SEL, 16'h0000, 1);
        wait_fs(3);
        check_eq("frame 1", 16'h01E0, 16'(fs_t[2] - fs_t[1]));
        check_eq("frame 2", 16'h0230, 16'(fs_t[3] - fs_t[2]));
        check_eq("frame ends", 16'h0002, 16'(cnt[6]));
        check_eq("line starts", 16'h0006, 16'(cnt[2]));
        check_eq("line ends", 16'h0006, 16'(cnt[5]));
        check_eq("emb lines", 16'h0004, 16'(cnt[3]));
        check_eq("pix lines", 16'h0004, 16'(cnt[4]));
        check_eq("link held", 16'h0002, {14'h0000, vid_link_o});
        for (int k = 0; k < 4; k++) check_eq("emb byte", e[k], emb_q[k]);
        check_eq("last pixel", 16'h0023, {6'h00, last_pix});
        stream_i = 0;
    endtask
    // link and pll words are taken at the next stream start
    task automatic scen_ccp(input logic [1:0] l);
        wr(`SVOF_A_LINK_SEL, {14'h0000, l}, 1);
        wr(`SVOF_A_X_START, 16'h0002, 2);
        wr(`SVOF_A_Y_START, 16'h0002, 2);
        restart();
        wait_fs(2);
        check_eq("window pixel", 16'h0065, {6'h00, last_pix});
        check_eq("ccp frame", 16'h0460, 16'(fs_t[2] - fs_t[1]));
        check_eq("link out", {14'h0000, l}, {14'h0000, vid_link_o});
        stream_i = 0;
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        rstn_i = 0;
        stream_i = 0;
        reg_we_i = 0;
        reg_addr_i = 16'h0000;
        reg_wdata_i = 8'h00;
        repeat (3) @(posedge ref_clk_i);
        #1 rstn_i = 1;
        scen_reset();
        scen_csi();
        scen_ccp(`SVOF_LINK_CCP_DC);
        scen_ccp(`SVOF_LINK_CCP_DS);
        give_verdict();
    end
endmodule
`default_nettype wire
